/* File: asp_monitor.sv */
// Checker on the top ports of the two-port serial block.
// Assumes a bind into asp_serial and a single clock domain.
`timescale 1ns/100ps
`default_nettype none
module asp_monitor (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  // Bus side
  input wire logic        hsel_in,
  input wire logic [9:0]  haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic [31:0] hrdata_out,
  // Serial side
  input wire logic [1:0]  cts_b_in,
  input wire logic [1:0]  txd_out,
  input wire logic [1:0]  irq_out
);
  logic       take;   // Transfer taken at this edge
  logic       rd_q;   // Last taken transfer was a read
  logic [9:0] adr_q;  // Address of last taken transfer
  assign take = hsel_in & hready_in & htrans_in[1] & hreadyout_out;
  // Remember the last address phase
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) {rd_q, adr_q} <= 11'h000;
    else if (take) {rd_q, adr_q} <= {!hwrite_in, haddr_in};
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_resp_okay: assert property (hresp_out == 1'b0) else $error("response not okay");
  a_take_waits: assert property (take |=> !hreadyout_out) else $error("no wait state");
  a_one_wait: assert property ($fell(hreadyout_out) |=> hreadyout_out) else $error("wait too long");
  a_rdata_stands: assert property (hreadyout_out && $past(hreadyout_out) |-> $stable(hrdata_out))
    else $error("read data moved");
  a_status_cts:
    assert property ($rose(hreadyout_out) && rd_q && adr_q == 10'h208 |->
      hrdata_out[1] == !$past(cts_b_in[0]))
    else $error("handshake status wrong");
  a_unmapped_zero: assert property ($rose(hreadyout_out) && rd_q && adr_q == 10'h3fc |-> hrdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero:
    assert property (hrdata_out[31:16] == 16'h0000) else $error("upper data bits set");
  a_bit_hold:
    assert property ($fell(txd_out[0]) |=> !txd_out[0] [*8]) else $error("low bit too short");
  // Main scenarios seen
  c_read: cover property (take && !hwrite_in);
  c_start: cover property ($fell(txd_out[0]));
  c_irq: cover property ($rose(irq_out[0]));
endmodule : asp_monitor
`default_nettype wire

/* File: asp_pkg.sv */
// Package for the two-port asynchronous serial block: offsets, fields, types.
// Assumes a single 25 MHz clock and an AHB-Lite register bus in front.
`default_nettype none
package asp_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] P0_BASE  = 8'h80;
  localparam logic [7:0] P1_BASE  = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h02;
  localparam logic [7:0] OFF_TXD  = 8'h04;
  localparam logic [7:0] OFF_RXD  = 8'h06;
  localparam logic [7:0] OFF_DIV  = 8'h08;
  localparam int         BYTE_SH  = 2;
  // Frame formats
  localparam logic [2:0] MODE_1 = 3'h1;
  localparam logic [2:0] MODE_2 = 3'h2;
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [3:0] BITS_7 = 4'h7;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [3:0] FRAME_EXTRA = 4'h2;  // Start plus stop
  localparam logic [4:0] LONG_ADD    = 5'h03; // Long break is 2M+3 bits
  // Sixteen ticks per bit
  localparam logic [3:0] OVS_MID  = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam int         OVS_SH   = 4;
  // DMA field codes
  localparam logic [2:0] DMA_R0T1 = 3'h1;
  localparam logic [2:0] DMA_R1T0 = 3'h2;
  localparam logic [2:0] DMA_R0   = 3'h4;
  localparam logic [2:0] DMA_R1   = 3'h5;
  localparam logic [2:0] DMA_T0   = 3'h6;
  localparam logic [2:0] DMA_T1   = 3'h7;

  // Control register layout
  typedef struct packed {
    logic [2:0] dma;
    logic       rx_status_int_en;
    logic       send_break;
    logic       tx_ninth_bit;
    logic       flow_ctrl_enable;
    logic       tx_ready_int_en;
    logic       rx_ready_int_en;
    logic       tx_machine_enable;
    logic       rx_machine_enable;
    logic       even_parity_sel;
    logic       parity_enable;
    logic [2:0] mode;
  } asp_ctrl_type;

  // Status register layout
  typedef struct packed {
    logic [4:0] rsvd_hi;
    logic       long_break_flag;
    logic       short_break_flag;
    logic       rx_ninth_bit;
    logic       rx_data_valid;
    logic       tx_hold_empty;
    logic       framing_flag;
    logic       overrun_flag;
    logic       parity_err_flag;
    logic       tx_shift_idle;
    logic       handshake_in_inv;
    logic       rsvd_lo;
  } asp_stat_type;

  // Register access strobe toward one port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  off;
    logic [15:0] wdata;
  } asp_req_type;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} asp_rx_state_type;
  typedef enum logic {TX_IDLE, TX_SHIFT} asp_tx_state_type;

  // Whole state of one port
  typedef struct packed {
    asp_ctrl_type     ctrl;
    logic [15:0]      div;
    logic [15:0]      baud_cnt;
    logic             tick;
    asp_stat_type     stat;
    logic [7:0]       thr;
    logic [7:0]       rbr;
    asp_tx_state_type tx_st;
    logic [10:0]      tx_sh;
    logic [3:0]       tx_left;
    logic [3:0]       tx_ph;
    asp_rx_state_type rx_st;
    logic [3:0]       rx_ph;
    logic [3:0]       rx_bitn;
    logic [9:0]       rx_sh;
    logic [9:0]       low_cnt;
    logic             txd;
    logic             rtr_b;
    logic             irq;
    logic [1:0]       dreq;
  } asp_port_type;

  // Whole state of the bus front end
  typedef struct packed {
    logic        pend;
    logic        wr;
    logic        hit0;
    logic        hit1;
    logic [7:0]  off;
    logic        hready;
    logic [31:0] hrdata;
    logic [1:0]  dreq;
  } asp_bus_type;

  // Receive channel of a DMA code: {used, channel}
  function automatic logic [1:0] dma_rx(input logic [2:0] c);
    unique case (c)
      DMA_R0T1, DMA_R0: dma_rx = 2'h2;
      DMA_R1T0, DMA_R1: dma_rx = 2'h3;
      default:          dma_rx = 2'h0;
    endcase
  endfunction : dma_rx

  // Transmit channel of a DMA code: {used, channel}
  function automatic logic [1:0] dma_tx(input logic [2:0] c);
    unique case (c)
      DMA_R1T0, DMA_T0: dma_tx = 2'h2;
      DMA_R0T1, DMA_T1: dma_tx = 2'h3;
      default:          dma_tx = 2'h0;
    endcase
  endfunction : dma_tx
endpackage : asp_pkg
`default_nettype wire

/* File: asp_serial.sv */
// Two asynchronous serial ports behind an AHB-Lite slave.
// Assumes one clock, pins synchronous to it, and an active-low async reset.
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// One serial port: registers, baud tick, transmitter, receiver
module asp_port (
  // Clock and synchronised reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_b_in,
  // Register access
  input  wire asp_pkg::asp_req_type  req_in,
  output logic [15:0]                rdata_out,
  // Serial pins
  input  wire logic                  rxd_in,
  input  wire logic                  cts_b_in,
  output logic                       txd_out,
  output logic                       rtr_b_out,
  // Requests
  output logic                       irq_out,
  output logic [1:0]                 dreq_out
);
  asp_pkg::asp_port_type s_q, s_d;   // Current and next state
  asp_pkg::asp_stat_type stat_rd;    // Status as read
  logic [3:0]            nb;         // Bits after start, before stop
  logic [3:0]            mbits;      // Whole frame length M
  logic [8:0]            w9;         // Character bits to send
  logic                  par7;       // Parity over seven bits
  logic                  par8;       // Parity over eight bits
  logic                  rx_err;     // Any receive status flag
  logic [1:0]            rxc;        // Receive DMA channel
  logic [1:0]            txc;        // Transmit DMA channel

  localparam asp_pkg::asp_port_type RST = '{
    stat: '{tx_hold_empty: 1'b1, tx_shift_idle: 1'b1, default: 1'b0},
    tx_st: asp_pkg::TX_IDLE, rx_st: asp_pkg::RX_IDLE,
    txd: 1'b1, rtr_b: 1'b1, default: '0};

  // Frame length from mode
  always_comb begin
    unique case (s_q.ctrl.mode)
      asp_pkg::MODE_4: nb = asp_pkg::BITS_7;
      asp_pkg::MODE_1: nb = asp_pkg::BITS_8;
      default:         nb = asp_pkg::BITS_9;
    endcase
    mbits = nb + asp_pkg::FRAME_EXTRA;
  end

  // Read view of status and register mux
  always_comb begin
    stat_rd                  = s_q.stat;
    stat_rd.rsvd_hi          = '0;
    stat_rd.rsvd_lo          = 1'b0;
    stat_rd.handshake_in_inv = ~cts_b_in;
    unique case (req_in.off)
      asp_pkg::OFF_CTRL: rdata_out = s_q.ctrl;
      asp_pkg::OFF_STAT: rdata_out = stat_rd;
      asp_pkg::OFF_RXD:  rdata_out = {8'h00, s_q.rbr};
      asp_pkg::OFF_DIV:  rdata_out = s_q.div;
      default:           rdata_out = 16'h0000;
    endcase
  end

  // Next-state logic of the whole port
  always_comb begin
    s_d  = s_q;
    rxc  = asp_pkg::dma_rx(s_q.ctrl.dma);
    txc  = asp_pkg::dma_tx(s_q.ctrl.dma);
    par7 = ^s_q.thr[6:0] ^ ~s_q.ctrl.even_parity_sel;
    par8 = ^s_q.thr ^ ~s_q.ctrl.even_parity_sel;
    // Character to send, ninth bit or parity on top
    w9 = {1'b1, s_q.thr};
    unique case (s_q.ctrl.mode)
      asp_pkg::MODE_1: if (s_q.ctrl.parity_enable) w9[7] = par7;
      asp_pkg::MODE_2: w9[8] = s_q.ctrl.tx_ninth_bit;
      asp_pkg::MODE_3: w9[8] = s_q.ctrl.parity_enable ? par8
                                                      : s_q.ctrl.tx_ninth_bit;
      asp_pkg::MODE_4: w9[7] = 1'b1;
      default: ;
    endcase
    // Baud tick every divisor clocks, sixteen per bit
    s_d.tick = 1'b0;
    if (s_q.div == 16'h0000) begin
      s_d.baud_cnt = 16'h0000;
    end else if (s_q.baud_cnt == 16'h0000) begin
      s_d.baud_cnt = s_q.div - 16'h0001;
      s_d.tick     = 1'b1;
    end else begin
      s_d.baud_cnt = s_q.baud_cnt - 16'h0001;
    end

    // Transmitter
    unique case (s_q.tx_st)
      asp_pkg::TX_IDLE: begin
        if (s_q.ctrl.tx_machine_enable && !s_q.stat.tx_hold_empty &&
            (!s_q.ctrl.flow_ctrl_enable || !cts_b_in)) begin
          s_d.tx_st              = asp_pkg::TX_SHIFT;
          s_d.tx_sh              = {1'b1, w9, 1'b0};
          s_d.tx_left            = mbits;
          s_d.tx_ph              = 4'h0;
          s_d.stat.tx_hold_empty = 1'b1;
          s_d.stat.tx_shift_idle = 1'b0;
        end
      end
      asp_pkg::TX_SHIFT: begin
        if (!s_q.ctrl.tx_machine_enable) begin
          s_d.tx_st              = asp_pkg::TX_IDLE;
          s_d.stat.tx_shift_idle = 1'b1;
        end else if (s_q.tick) begin
          s_d.tx_ph = s_q.tx_ph + 4'h1;
          if (s_q.tx_ph == asp_pkg::OVS_LAST) begin
            s_d.tx_sh   = {1'b1, s_q.tx_sh[10:1]};
            s_d.tx_left = s_q.tx_left - 4'h1;
            if (s_q.tx_left == 4'h1) begin
              s_d.tx_st              = asp_pkg::TX_IDLE;
              s_d.stat.tx_shift_idle = 1'b1;
              s_d.ctrl.tx_ninth_bit  = 1'b0;
            end
          end
        end
      end
    endcase

    // Software access; flag writes of zero clear
    if (req_in.wr) begin
      unique case (req_in.off)
        asp_pkg::OFF_CTRL: s_d.ctrl = req_in.wdata;
        asp_pkg::OFF_STAT: begin
          s_d.stat.long_break_flag  = s_q.stat.long_break_flag & req_in.wdata[10];
          s_d.stat.short_break_flag = s_q.stat.short_break_flag & req_in.wdata[9];
          s_d.stat.rx_ninth_bit     = s_q.stat.rx_ninth_bit & req_in.wdata[8];
          s_d.stat.framing_flag     = s_q.stat.framing_flag & req_in.wdata[5];
          s_d.stat.overrun_flag     = s_q.stat.overrun_flag & req_in.wdata[4];
          s_d.stat.parity_err_flag  = s_q.stat.parity_err_flag & req_in.wdata[3];
        end
        asp_pkg::OFF_TXD: begin
          s_d.thr                = req_in.wdata[7:0];
          s_d.stat.tx_hold_empty = 1'b0;
        end
        asp_pkg::OFF_DIV:  s_d.div = req_in.wdata;
        default: ;
      endcase
    end
    if (req_in.rd && req_in.off == asp_pkg::OFF_RXD) begin
      s_d.stat.rx_data_valid = 1'b0;
    end

    // Break watch: count low ticks on the receive line
    if (rxd_in) begin
      s_d.low_cnt = '0;
    end else if (s_q.tick && s_q.low_cnt != '1) begin
      s_d.low_cnt = s_q.low_cnt + 10'h001;
    end
    if (s_q.ctrl.rx_machine_enable && !rxd_in) begin
      if (s_q.low_cnt > {2'b00, mbits, 4'h0}) begin
        s_d.stat.short_break_flag = 1'b1;
      end
      if (s_q.low_cnt > {1'b0, ({1'b0, mbits} << 1) + asp_pkg::LONG_ADD, 4'h0}) begin
        s_d.stat.long_break_flag = 1'b1;
      end
    end

    // Receiver, sixteen ticks and one mid-bit sample per bit
    unique case (s_q.rx_st)
      asp_pkg::RX_IDLE: begin
        if (s_q.ctrl.rx_machine_enable && !rxd_in) begin
          s_d.rx_st = asp_pkg::RX_START;
          s_d.rx_ph = 4'h0;
        end
      end
      asp_pkg::RX_START: begin
        if (s_q.tick) begin
          s_d.rx_ph = s_q.rx_ph + 4'h1;
          if (s_q.rx_ph == asp_pkg::OVS_MID) begin
            s_d.rx_st   = rxd_in ? asp_pkg::RX_IDLE : asp_pkg::RX_BITS;
            s_d.rx_ph   = 4'h0;
            s_d.rx_bitn = 4'h0;
          end
        end
      end
      asp_pkg::RX_BITS: begin
        if (s_q.tick) begin
          s_d.rx_ph = s_q.rx_ph + 4'h1;
          if (s_q.rx_ph == asp_pkg::OVS_LAST) begin
            s_d.rx_sh[s_q.rx_bitn] = rxd_in;
            s_d.rx_bitn            = s_q.rx_bitn + 4'h1;
            if (s_q.rx_bitn == nb) begin
              s_d.rx_st = asp_pkg::RX_IDLE;
              // Mode 2 drops characters whose ninth bit is zero
              if (!(s_q.ctrl.mode == asp_pkg::MODE_2 && !s_q.rx_sh[8])) begin
                if (s_q.stat.rx_data_valid) s_d.stat.overrun_flag = 1'b1;
                if (!rxd_in) s_d.stat.framing_flag = 1'b1;
                s_d.stat.rx_data_valid = 1'b1;
                s_d.rbr = s_q.rx_sh[7:0];
                unique case (s_q.ctrl.mode)
                  asp_pkg::MODE_1: if (s_q.ctrl.parity_enable) begin
                    s_d.rbr[7] = 1'b0;
                    if (^s_q.rx_sh[7:0] ^ ~s_q.ctrl.even_parity_sel)
                      s_d.stat.parity_err_flag = 1'b1;
                  end
                  asp_pkg::MODE_2: s_d.stat.rx_ninth_bit = s_q.rx_sh[8];
                  asp_pkg::MODE_3: begin
                    s_d.stat.rx_ninth_bit = s_q.rx_sh[8];
                    if (s_q.ctrl.parity_enable &&
                        (^s_q.rx_sh[8:0] ^ ~s_q.ctrl.even_parity_sel))
                      s_d.stat.parity_err_flag = 1'b1;
                  end
                  asp_pkg::MODE_4: s_d.rbr[7] = 1'b0;
                  default: ;
                endcase
              end
            end
          end
        end
      end
      default: s_d.rx_st = asp_pkg::RX_IDLE;
    endcase
    if (!s_q.ctrl.rx_machine_enable) s_d.rx_st = asp_pkg::RX_IDLE;

    // Pins and requests from the next state
    s_d.txd   = s_d.ctrl.send_break ? 1'b0 : s_d.tx_sh[0] | (s_d.tx_st == asp_pkg::TX_IDLE);
    s_d.rtr_b = s_d.ctrl.flow_ctrl_enable &
                (s_d.stat.rx_data_valid | ~s_d.ctrl.rx_machine_enable);
    rx_err    = s_d.stat.long_break_flag | s_d.stat.short_break_flag |
                s_d.stat.framing_flag | s_d.stat.overrun_flag | s_d.stat.parity_err_flag;
    rxc       = asp_pkg::dma_rx(s_d.ctrl.dma);
    txc       = asp_pkg::dma_tx(s_d.ctrl.dma);
    s_d.irq   = (s_d.ctrl.rx_status_int_en & rx_err) |
                (s_d.ctrl.tx_ready_int_en & s_d.stat.tx_hold_empty &
                 ~txc[1]) |
                (s_d.ctrl.rx_ready_int_en & s_d.stat.rx_data_valid &
                 ~rxc[1]);
    for (int c = 0; c < 2; c++) begin
      s_d.dreq[c] = (rxc[1] & (rxc[0] == c[0]) & s_d.stat.rx_data_valid) |
                    (txc[1] & (txc[0] == c[0]) & s_d.stat.tx_hold_empty);
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) s_q <= RST;
    else           s_q <= s_d;
  end

  assign txd_out   = s_q.txd;
  assign rtr_b_out = s_q.rtr_b;
  assign irq_out   = s_q.irq;
  assign dreq_out  = s_q.dreq;
endmodule : asp_port

// Notes on behaviour
// - DMA field picks receive and transmit channels
// - Status interrupt on errors or breaks when enabled
// - Send-break holds serial output low
// - Low over M bits short, 2M+3 long
// - Break flags stick until software clears
// - Ninth bit sent in modes 2, 3; cleared after
// - Handshake lines gate only with flow control
// - Transmit interrupt while holding register empty
// - Receive interrupt while data valid
// - Enable bits run transmit and receive machines
// - Optional parity, even or odd select
// - Mode field selects 7, 8 or 9 bits
// - Received ninth bit reloaded by each mode 3 and each kept mode 2 character
// - Data valid cleared only by data read
// - Holding empty cleared by transmit write
// - Framing, overrun, parity flags stick
// - Shifter idle flag tracks shift register
// - Handshake status is inverted clear-to-send
// - Transmit data uses low byte only
// - Bit rate is clock over sixteen times divisor
// - Second port repeats the register set
// - Mode 2 drops characters with ninth bit zero
// - Transmit DMA suppresses transmit interrupt
module asp_serial (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [9:0]  haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  // Serial pins, one per port
  input  wire logic [1:0]  rxd_in,
  input  wire logic [1:0]  cts_b_in,
  output logic [1:0]       txd_out,
  output logic [1:0]       rtr_b_out,
  // Interrupts per port and DMA requests per channel
  output logic [1:0]       irq_out,
  output logic [1:0]       dreq_out
);
  logic [1:0]             rst_sync_q;  // Reset release chain
  logic                   rst_b;       // Synchronised reset
  asp_pkg::asp_bus_type   b_q, b_d;    // Bus front state
  asp_pkg::asp_req_type   req0, req1;  // Strobes to each port
  logic [15:0]            rd0, rd1;    // Read data of each port
  logic [1:0]             dr0, dr1;    // DMA requests of each port
  logic [7:0]             idx;         // Register index of address
  logic                   unused_sz;   // Size is always a word

  localparam asp_pkg::asp_bus_type BRST = '{hready: 1'b1, default: '0};

  // Release reset through two flops
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) rst_sync_q <= 2'b00;
    else           rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_b     = rst_sync_q[1];
  assign unused_sz = ^hsize_in;

  // Strobes in the data phase; receive-buffer read clears valid
  always_comb begin
    req0       = '0;
    req1       = '0;
    req0.off   = b_q.off;
    req1.off   = b_q.off;
    req0.wdata = hwdata_in[15:0];
    req1.wdata = hwdata_in[15:0];
    req0.wr    = b_q.pend & b_q.hit0 & b_q.wr;
    req0.rd    = b_q.pend & b_q.hit0 & ~b_q.wr;
    req1.wr    = b_q.pend & b_q.hit1 & b_q.wr;
    req1.rd    = b_q.pend & b_q.hit1 & ~b_q.wr;
  end

  // Address phase capture, one wait state, registered read data
  always_comb begin
    b_d      = b_q;
    idx      = haddr_in[9:asp_pkg::BYTE_SH];
    b_d.dreq = dr0 | dr1;
    if (b_q.pend) begin
      b_d.pend   = 1'b0;
      b_d.hready = 1'b1;
      b_d.hrdata = {16'h0000, b_q.hit0 ? rd0 : (b_q.hit1 ? rd1 : 16'h0000)};
    end else if (hsel_in && hready_in && htrans_in[1]) begin
      b_d.pend   = 1'b1;
      b_d.hready = 1'b0;
      b_d.wr     = hwrite_in;
      b_d.hit0   = haddr_in[1:0] == 2'b00 && idx >= asp_pkg::P0_BASE &&
                   idx <= asp_pkg::P0_BASE + asp_pkg::OFF_DIV && !idx[0];
      b_d.hit1   = haddr_in[1:0] == 2'b00 && idx >= asp_pkg::P1_BASE &&
                   idx <= asp_pkg::P1_BASE + asp_pkg::OFF_DIV && !idx[0];
      b_d.off    = b_d.hit0 ? idx - asp_pkg::P0_BASE : idx - asp_pkg::P1_BASE;
    end
  end

  // Bus state register
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) b_q <= BRST;
    else        b_q <= b_d;
  end

  // Port 0
  asp_port u_port0 (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b),
    .req_in    (req0),
    .rdata_out (rd0),
    .rxd_in    (rxd_in[0]),
    .cts_b_in  (cts_b_in[0]),
    .txd_out   (txd_out[0]),
    .rtr_b_out (rtr_b_out[0]),
    .irq_out   (irq_out[0]),
    .dreq_out  (dr0)
  );

  // Port 1, same register set
  asp_port u_port1 (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b),
    .req_in    (req1),
    .rdata_out (rd1),
    .rxd_in    (rxd_in[1]),
    .cts_b_in  (cts_b_in[1]),
    .txd_out   (txd_out[1]),
    .rtr_b_out (rtr_b_out[1]),
    .irq_out   (irq_out[1]),
    .dreq_out  (dr1)
  );

  assign hreadyout_out = b_q.hready;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = b_q.hrdata;
  assign dreq_out      = b_q.dreq;
endmodule : asp_serial
`default_nettype wire

/* File: asp_term_model.sv */
// Remote serial terminal on port 0: sends frames, catches frames.
// Assumes the port's divisor register holds DIV.
`timescale 1ns/100ps
`default_nettype none
module asp_term_model #(
  parameter int DIV = 1  // Divisor the port uses
) (
  // Clock and line
  input  wire logic clk_in,
  input  wire logic txd_in,
  output logic      rxd_out,
  output logic      cts_b_out
);
  localparam int BT = 16 * DIV;  // Clocks per bit
  // Idle mark, always clear to send
  initial begin
    rxd_out   = 1'b0 ^ 1'b1;
    cts_b_out = 1'b0;
  end
  // Hold one level for k clocks
  task automatic level(input logic b, input int k);
    @(posedge clk_in);
    rxd_out <= b;
    repeat (k - 1) @(posedge clk_in);
  endtask : level
  // Start, n bits LSB first, one stop
  task automatic send(input int n, input logic [8:0] d);
    level(1'b0, BT);
    for (int i = 0; i < n; i++) level(d[i], BT);
    level(1'b1, BT);
  endtask : send
  // Catch n bits and the stop, sampled mid-bit
  task automatic recv(input int n, output logic [9:0] d);
    d = 10'h000;
    do @(negedge clk_in); while (txd_in !== 1'b0);
    repeat (BT / 2) @(negedge clk_in);
    for (int i = 0; i <= n; i++) begin
      repeat (BT) @(negedge clk_in);
      d[i] = txd_in;
    end
  endtask : recv
endmodule : asp_term_model
`default_nettype wire

/* File: tb_top.sv */
// Bench for the two-port serial block, port 0 faced by a terminal model.
// Assumes asp_pkg, asp_serial, the checker and the terminal compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [7:0]  CT = asp_pkg::OFF_CTRL, ST = asp_pkg::OFF_STAT;
  localparam logic [7:0]  TX = asp_pkg::OFF_TXD, RX = asp_pkg::OFF_RXD;
  localparam logic [15:0] DTX = 16'h9018;  // Transmit channel per DMA code
  logic        clk_in, rst_b_in, hsel_in, hwrite_in, hresp_out, hreadyout_out;
  logic        term_rxd, term_cts;  // Terminal line
  logic [1:0]  htrans_in, txd_out, rtr_b_out, irq_out, dreq_out, rxd_in, cts_b_in;
  logic [2:0]  hsize_in;
  logic [9:0]  haddr_in, f;
  logic [31:0] hwdata_in, hrdata_out, v;
  int          fail_count, checks, cyc, nb;
  assign rxd_in   = {1'b1, term_rxd};  // Port 1 line idle
  assign cts_b_in = {1'b1, term_cts};
  asp_serial dut (.clk_in, .rst_b_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hsize_in, .hwdata_in, .hready_in(hreadyout_out), .hreadyout_out, .hresp_out,
    .hrdata_out, .rxd_in, .cts_b_in, .txd_out, .rtr_b_out, .irq_out, .dreq_out);
  asp_term_model #(.DIV(1)) term (.clk_in, .txd_in(txd_out[0]), .rxd_out(term_rxd),
    .cts_b_out(term_cts));
  // Clock and hang guard
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // Score one comparison
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // One single AHB-Lite transfer, held until ready
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    logic r;
    @(posedge clk_in);
    {hsel_in, htrans_in, haddr_in, hwrite_in} <= {1'b1, 2'h2, a, w};
    do begin
      @(negedge clk_in);
      r = hreadyout_out;
      @(posedge clk_in);
    end while (!r);
    {htrans_in, hwdata_in} <= {2'h0, wd};
    do begin
      @(negedge clk_in);
      {r, rd} = {hreadyout_out, hrdata_out};
      @(posedge clk_in);
    end while (!r);
  endtask : bus
  function automatic logic [9:0] adr(input logic p, input logic [7:0] o);
    adr = {(p ? asp_pkg::P1_BASE : asp_pkg::P0_BASE) + o, 2'b00};
  endfunction : adr
  task automatic wr(input logic p, input logic [7:0] o, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, adr(p, o), d, x);
  endtask : wr
  task automatic rchk(input logic p, input logic [7:0] o, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, adr(p, o), 32'h0, x);
    chk($sformatf("reg %h", adr(p, o)), x, e);
  endtask : rchk
  // Counts, verdict, end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    {rst_b_in, hsel_in, hwrite_in, htrans_in, haddr_in, hwdata_in} = '0;
    hsize_in = 3'h2;
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rchk(0, ST, 32'h46);
    rchk(1, ST, 32'h44);
    wr(0, asp_pkg::OFF_DIV, 32'h1);
    rchk(0, asp_pkg::OFF_DIV, 32'h1);
    bus(1'b0, 10'h3fc, 32'h0, v);
    chk("unmapped", v, 32'h0);
    $display("test registers ended");
    for (int m = 1; m <= 4; m++) begin
      nb = (m == 4) ? 7 : (m == 1) ? 8 : 9;
      wr(0, CT, 32'h440 | m);
      fork
        wr(0, TX, 32'h15a);
        term.recv(nb, f);
      join
      chk("frame", f, (10'h1 << nb) | ((m == 2 || m == 3) ? 10'h15a : 10'h05a));
      repeat (24) @(posedge clk_in);
      rchk(0, CT, 32'h40 | m);
    end
    wr(0, CT, 32'h841);
    wr(0, TX, 32'hff);
    repeat (4) begin
      repeat (40) @(negedge clk_in);
      chk("txd", txd_out, 32'h2);
    end
    wr(0, CT, 32'h41);
    repeat (300) @(negedge clk_in);
    chk("txd", txd_out, 32'h3);
    $display("test transmit ended");
    wr(0, CT, 32'ha1);
    term.send(8, 9'h0a5);
    @(negedge clk_in);
    chk("irq", irq_out, 32'h1);
    rchk(0, ST, 32'hc6);
    rchk(0, RX, 32'ha5);
    rchk(0, ST, 32'h46);
    term.send(8, 9'h0a5);
    term.send(8, 9'h0a5);
    rchk(0, ST, 32'hd6);
    rchk(0, RX, 32'ha5);
    wr(0, CT, 32'h1039);
    wr(0, ST, 32'h0);
    term.send(8, 9'h001);
    @(negedge clk_in);
    chk("irq", irq_out, 32'h1);
    rchk(0, ST, 32'hce);
    rchk(0, RX, 32'h01);
    wr(0, ST, 32'h0);
    term.send(8, 9'h081);
    rchk(0, ST, 32'hc6);
    rchk(0, RX, 32'h01);
    wr(0, CT, 32'h21);
    term.level(1'b0, 400);
    term.level(1'b1, 80);
    bus(1'b0, adr(0, ST), 32'h0, v);
    chk("break", v & 32'hff7f, 32'h676);
    bus(1'b0, adr(0, RX), 32'h0, v);
    wr(0, ST, 32'h0);
    rchk(0, ST, 32'h46);
    wr(0, CT, 32'h22);
    term.send(9, 9'h033);
    rchk(0, ST, 32'h46);
    term.send(9, 9'h133);
    rchk(0, ST, 32'h1c6);
    rchk(0, RX, 32'h33);
    $display("test receive ended");
    wr(0, CT, 32'h200);
    @(negedge clk_in);
    chk("rtr", rtr_b_out, 32'h1);
    wr(0, CT, 32'h0);
    @(negedge clk_in);
    chk("rtr", rtr_b_out, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(0, CT, (c << 13) | 32'h100);
      repeat (3) @(negedge clk_in);
      chk("dreq", dreq_out, DTX[2 * c +: 2]);
      chk("irq", irq_out, DTX[2 * c +: 2] == 2'h0);
    end
    $display("test dma ended");
    report_and_stop();
  end
endmodule : tb_top
bind asp_serial asp_monitor mon (.clk_in, .rst_b_in, .hsel_in, .haddr_in, .htrans_in,
  .hwrite_in, .hready_in, .hreadyout_out, .hresp_out, .hrdata_out, .cts_b_in, .txd_out,
  .irq_out);
`default_nettype wire
